// ==== pfsel_map.svh ====
`ifndef PFSEL_MAP_SVH
`define PFSEL_MAP_SVH

// register byte offsets on the AXI4-Lite slave
`define PFSEL_OFS_UPPER 8'h00
`define PFSEL_OFS_LOWER 8'h04
`define PFSEL_OFS_DIR 8'h08
`define PFSEL_OFS_DATA 8'h0C
`define PFSEL_OFS_STATUS 8'h10

// reset values
`define PFSEL_UPPER_RST 16'h0015
`define PFSEL_LOWER_RST 16'h5000
`define PFSEL_DIR_RST 16'h0000
`define PFSEL_DATA_RST 16'h0000

// writable bits; reserved bits hold zero
`define PFSEL_UPPER_MASK 16'hD555
`define PFSEL_LOWER_MASK 16'h5D55

// field positions in the upper function register
`define PFSEL_CLK_TRISTATE_BIT 15
`define PFSEL_PIN15_BIT 14
`define PFSEL_PIN14_BIT 12
`define PFSEL_PIN13_BIT 10
`define PFSEL_PIN12_BIT 8
`define PFSEL_PIN11_BIT 6
`define PFSEL_PIN10_BIT 4
`define PFSEL_PIN9_BIT 2
`define PFSEL_PIN8_BIT 0

// upper pins whose external-bus function drives the pin (14 down to 9)
`define PFSEL_PERIPH_OE 8'h7E

// bus responses
`define PFSEL_RESP_OKAY 2'h0
`define PFSEL_RESP_SLVERR 2'h2

`endif

// ==== pfsel_pkg.sv ====
package pfsel_pkg;

  typedef enum logic [1:0] {
    PFSEL_ST_IDLE = 2'b00,
    PFSEL_ST_RESP = 2'b01
  } pfsel_axi_state_type;

  typedef struct packed {
    logic sel;
    logic dir;
    logic gpio_data;
    logic periph_data;
    logic periph_oe;
  } pfsel_pin_ctrl_type;

  typedef struct packed {
    logic data;
    logic oe;
  } pfsel_pin_drive_type;

endpackage

// ==== pfsel_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none

module pfsel_pin_cell (
  input wire pfsel_pkg::pfsel_pin_ctrl_type ctrl_in,
  output var pfsel_pkg::pfsel_pin_drive_type drive_out
);

  always_comb begin
    if (ctrl_in.sel) begin
      drive_out.data = ctrl_in.periph_data;
      drive_out.oe = ctrl_in.periph_oe;
    end else begin
      drive_out.data = ctrl_in.gpio_data;
      drive_out.oe = ctrl_in.dir;
    end
  end

endmodule

`default_nettype wire

// ==== pfsel_top.sv ====
// Operation
// - reset loads upper 0x0015, lower 0x5000
// - standby and sleep leave registers untouched
// - upper governs pins 15-8, lower is only stored and read back
// - clock pin driven at 0, hi-z at 1
// - reserved upper bits read zero, write zero
// - bit 14 makes pin 15 bus request
// - bit 12 makes pin 14 bus acknowledge
// - bits 10,8,6 make chip selects 3-1
// - bit 4 makes pin 10 chip select 0
// - bit 2 makes pin 9 read strobe
// - bit 0 makes pin 8 wait input
// - gpio pins follow their direction bit
`include "pfsel_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pfsel_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic expanded_mode_in,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  output logic [7:0] pin_select_out,
  input wire logic clock_source_in,
  output logic clock_pin_out,
  output logic clock_pin_oe_out,
  input wire logic bus_ack_n_in,
  input wire logic [3:0] chip_select_n_in,
  input wire logic read_strobe_n_in,
  output logic bus_request_n_out,
  output logic wait_request_n_out
);

  pfsel_pkg::pfsel_axi_state_type wstate_q;
  pfsel_pkg::pfsel_axi_state_type rstate_q;
  logic aw_have_q;
  logic [7:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] dir_q;
  logic [15:0] data_q;
  logic [7:0] pin_data_q;
  logic [7:0] pin_oe_q;
  logic bus_request_n_q;
  logic wait_request_n_q;
  logic wr_go;
  logic wr_upper, wr_lower, wr_dir, wr_data, wr_err;
  logic [31:0] rd_data_d;
  logic [1:0] rd_resp_d;
  logic [7:0] sel_eff;
  logic [7:0] periph_data;
  logic [7:0] port_read;
  logic [15:0] wr_data16;
  logic written_q;
  pfsel_pkg::pfsel_pin_ctrl_type ctrl_w [8];
  pfsel_pkg::pfsel_pin_drive_type drive_w [8];

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m = old_v;
    if (strb[0]) begin
      m[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      m[15:8] = new_v[15:8];
    end
    return m & mask;
  endfunction

  // write channel: address and data may arrive in either order
  assign s_axi_awready_out = (wstate_q == pfsel_pkg::PFSEL_ST_IDLE) && !aw_have_q;
  assign s_axi_wready_out = (wstate_q == pfsel_pkg::PFSEL_ST_IDLE) && !w_have_q;
  assign wr_go = (wstate_q == pfsel_pkg::PFSEL_ST_IDLE) && aw_have_q && w_have_q;
  assign s_axi_bvalid_out = (wstate_q == pfsel_pkg::PFSEL_ST_RESP);
  assign s_axi_bresp_out = bresp_q;
  assign wr_data16 = w_data_q[15:0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_in;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata_in;
      w_strb_q <= s_axi_wstrb_in;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_comb begin
    wr_upper = 1'b0;
    wr_lower = 1'b0;
    wr_dir = 1'b0;
    wr_data = 1'b0;
    wr_err = 1'b0;
    if (aw_addr_q == `PFSEL_OFS_UPPER) begin
      wr_upper = 1'b1;
    end else if (aw_addr_q == `PFSEL_OFS_LOWER) begin
      wr_lower = 1'b1;
    end else if (aw_addr_q == `PFSEL_OFS_DIR) begin
      wr_dir = 1'b1;
    end else if (aw_addr_q == `PFSEL_OFS_DATA) begin
      wr_data = 1'b1;
    end else if (aw_addr_q != `PFSEL_OFS_STATUS) begin
      wr_err = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wstate_q <= pfsel_pkg::PFSEL_ST_IDLE;
      bresp_q <= `PFSEL_RESP_OKAY;
    end else begin
      case (wstate_q)
        pfsel_pkg::PFSEL_ST_IDLE: begin
          if (wr_go) begin
            wstate_q <= pfsel_pkg::PFSEL_ST_RESP;
            bresp_q <= wr_err ? `PFSEL_RESP_SLVERR : `PFSEL_RESP_OKAY;
          end
        end
        default: begin
          if (s_axi_bready_in) begin
            wstate_q <= pfsel_pkg::PFSEL_ST_IDLE;
          end
        end
      endcase
    end
  end

  // watchdog, sleep and standby exit never reach rst_in, so state survives
  // reset loads values
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      upper_q <= `PFSEL_UPPER_RST;
      lower_q <= `PFSEL_LOWER_RST;
    end else if (wr_go && wr_upper) begin
      upper_q <= merge16(upper_q, wr_data16, w_strb_q, `PFSEL_UPPER_MASK);
    end else if (wr_go && wr_lower) begin
      lower_q <= merge16(lower_q, wr_data16, w_strb_q, `PFSEL_LOWER_MASK);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_q <= `PFSEL_DIR_RST;
      data_q <= `PFSEL_DATA_RST;
    end else if (wr_go && wr_dir) begin
      dir_q <= merge16(dir_q, wr_data16, w_strb_q, 16'hFFFF);
    end else if (wr_go && wr_data) begin
      data_q <= merge16(data_q, wr_data16, w_strb_q, 16'hFFFF);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      written_q <= 1'b0;
    end else if (wr_go) begin
      written_q <= 1'b1;
    end
  end

  // read channel: one cycle from address to data
  assign s_axi_arready_out = (rstate_q == pfsel_pkg::PFSEL_ST_IDLE);
  assign s_axi_rvalid_out = (rstate_q == pfsel_pkg::PFSEL_ST_RESP);
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  // output pins read back their latch, input pins the pad
  assign port_read = (dir_q[15:8] & data_q[15:8]) | (~dir_q[15:8] & pin_in);

  always_comb begin
    rd_data_d = 32'h0000_0000;
    rd_resp_d = `PFSEL_RESP_OKAY;
    if (s_axi_araddr_in == `PFSEL_OFS_UPPER) begin
      rd_data_d[15:0] = upper_q;
    end else if (s_axi_araddr_in == `PFSEL_OFS_LOWER) begin
      rd_data_d[15:0] = lower_q;
    end else if (s_axi_araddr_in == `PFSEL_OFS_DIR) begin
      rd_data_d[15:0] = dir_q;
    end else if (s_axi_araddr_in == `PFSEL_OFS_DATA) begin
      rd_data_d[15:0] = {port_read, data_q[7:0]};
    end else if (s_axi_araddr_in == `PFSEL_OFS_STATUS) begin
      rd_data_d[8:0] = {expanded_mode_in, sel_eff};
    end else begin
      rd_resp_d = `PFSEL_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rstate_q <= pfsel_pkg::PFSEL_ST_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PFSEL_RESP_OKAY;
    end else begin
      case (rstate_q)
        pfsel_pkg::PFSEL_ST_IDLE: begin
          if (s_axi_arvalid_in) begin
            rstate_q <= pfsel_pkg::PFSEL_ST_RESP;
            rdata_q <= rd_data_d;
            rresp_q <= rd_resp_d;
          end
        end
        default: begin
          if (s_axi_rready_in) begin
            rstate_q <= pfsel_pkg::PFSEL_ST_IDLE;
          end
        end
      endcase
    end
  end

  // pin order 8..15: wait, read, cs0..cs3, bus ack, bus request
  // strobes to pins
  assign periph_data = {1'b1, bus_ack_n_in, chip_select_n_in, read_strobe_n_in, 1'b1};
  assign pin_select_out = sel_eff;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign sel_eff[gi] = expanded_mode_in & upper_q[2 * gi];
      assign ctrl_w[gi].sel = sel_eff[gi];
      assign ctrl_w[gi].dir = dir_q[8 + gi];
      assign ctrl_w[gi].gpio_data = data_q[8 + gi];
      assign ctrl_w[gi].periph_data = periph_data[gi];
      assign ctrl_w[gi].periph_oe = 1'(`PFSEL_PERIPH_OE >> gi);

      pfsel_pin_cell u_cell (
        .ctrl_in(ctrl_w[gi]),
        .drive_out(drive_w[gi])
      );

      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_data_q[gi] <= 1'b0;
          pin_oe_q[gi] <= 1'b0;
        end else begin
          pin_data_q[gi] <= drive_w[gi].data;
          pin_oe_q[gi] <= drive_w[gi].oe;
        end
      end
    end
  endgenerate

  assign pin_out = pin_data_q;
  assign pin_oe_out = pin_oe_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_request_n_q <= 1'b1;
      wait_request_n_q <= 1'b1;
    end else begin
      bus_request_n_q <= sel_eff[7] ? pin_in[7] : 1'b1;
      wait_request_n_q <= sel_eff[0] ? pin_in[0] : 1'b1;
    end
  end

  assign bus_request_n_out = bus_request_n_q;
  assign wait_request_n_out = wait_request_n_q;

  // the clock itself cannot come through a flop without halving it
  // clock pin enable
  assign clock_pin_out = clock_source_in;
  assign clock_pin_oe_out = !upper_q[`PFSEL_CLK_TRISTATE_BIT];

  AST_RESET_VALUES: assert property (@(posedge clk_in) disable iff (rst_in)
    !written_q |-> (upper_q == `PFSEL_UPPER_RST && lower_q == `PFSEL_LOWER_RST))
    else $error("function registers lost reset value");
  AST_HOLD_NO_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
    !(wr_go && (wr_upper || wr_lower)) |=> ($stable(upper_q) && $stable(lower_q)))
    else $error("function register changed without a write");
  AST_UPPER_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_go && wr_upper && w_strb_q[1:0] == 2'b11) |=>
      upper_q == ($past(wr_data16) & `PFSEL_UPPER_MASK))
    else $error("upper register write not stored");
  AST_CLOCK_HIZ: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_go && wr_upper && w_strb_q[1]) |=> clock_pin_oe_out == !$past(w_data_q[15]))
    else $error("clock pin enable does not follow write");
  AST_RSVD_READ: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `PFSEL_OFS_UPPER) |=>
      (s_axi_rvalid_out && (s_axi_rdata_out & ~{16'h0000, `PFSEL_UPPER_MASK}) == 32'h0000_0000))
    else $error("reserved upper bits read nonzero");
  // pin flops still hold reset values one edge after reset lifts
  AST_BUS_REQUEST: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN15_BIT]) |=>
      (bus_request_n_out == $past(pin_in[7]) && !pin_oe_out[7]))
    else $error("pin 15 not acting as bus request");
  AST_BUS_ACK: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN14_BIT]) |=>
      (pin_oe_out[6] && pin_out[6] == $past(bus_ack_n_in)))
    else $error("pin 14 not driving bus acknowledge");
  AST_CHIP_SEL3: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN13_BIT]) |=>
      (pin_oe_out[5] && pin_out[5] == $past(chip_select_n_in[3])))
    else $error("pin 13 not driving chip select 3");
  AST_CHIP_SEL1: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN11_BIT]) |=>
      (pin_oe_out[3] && pin_out[3] == $past(chip_select_n_in[1])))
    else $error("pin 11 not driving chip select 1");
  AST_CHIP_SEL0: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN10_BIT]) |=>
      (pin_oe_out[2] && pin_out[2] == $past(chip_select_n_in[0])))
    else $error("pin 10 not driving chip select 0");
  AST_READ_STROBE: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN9_BIT]) |=>
      (pin_oe_out[1] && pin_out[1] == $past(read_strobe_n_in)))
    else $error("pin 9 not driving read strobe");
  AST_WAIT_INPUT: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && expanded_mode_in && upper_q[`PFSEL_PIN8_BIT]) |=>
      (wait_request_n_out == $past(pin_in[0]) && !pin_oe_out[0]))
    else $error("pin 8 not acting as wait input");
  AST_GPIO_DIR: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && !expanded_mode_in) |=> (pin_oe_out == $past(dir_q[15:8]) && bus_request_n_out))
    else $error("single-chip pins do not follow direction");
  AST_WRITE_RESP: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out)
      |-> ##2 s_axi_bvalid_out)
    else $error("write response not two cycles after handshake");

endmodule

`default_nettype wire

// ==== pfsel_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pfsel_far_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  input wire logic bus_request_n_in,
  input wire logic wait_request_n_in,
  output logic [7:0] pad_out
);
  logic [5:0] float_q;

  // unpulled inputs wander, so a stale level never looks valid
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      float_q <= 6'h2A;
    end else begin
      float_q <= ~float_q;
    end
  end

  assign pad_out = (pin_oe_in & pin_out_in) |
    (~pin_oe_in & {bus_request_n_in, float_q, wait_request_n_in});
endmodule

`default_nettype wire

// ==== port_f_upper_pin_function_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pfsel_map.svh"

module port_f_upper_pin_function_select_tb;
  logic clk_in = 1'b0;
  logic rst_in;
  logic [7:0] awaddr, araddr, pin_in, pin_out, pin_oe, pin_sel, a;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, v, d;
  logic [3:0] wstrb, cs_n;
  logic [1:0] bresp, rresp, r;
  logic mode, clk_src, clk_pin, clk_oe, back_n, rd_n, req_n, wait_n, req_n_out, wait_n_out;
  logic [31:0] rng = 32'h0000_FD57;
  logic [15:0] up_m, lo_m, dir_m, dat_m;
  int fails = 0;
  int tests_run = 0;

  always #10 clk_in = ~clk_in;

  pfsel_top dut (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .expanded_mode_in(mode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe), .pin_select_out(pin_sel), .clock_source_in(clk_src),
    .clock_pin_out(clk_pin), .clock_pin_oe_out(clk_oe), .bus_ack_n_in(back_n),
    .chip_select_n_in(cs_n), .read_strobe_n_in(rd_n), .bus_request_n_out(req_n_out),
    .wait_request_n_out(wait_n_out));

  pfsel_far_model far (.clk_in(clk_in), .rst_in(rst_in), .pin_out_in(pin_out),
    .pin_oe_in(pin_oe), .bus_request_n_in(req_n), .wait_request_n_in(wait_n),
    .pad_out(pin_in));

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] x, logic [3:0] s,
                                       logic [15:0] m);
    logic [15:0] b;
    b = {{8{s[1]}}, {8{s[0]}}};
    return ((o & ~b) | (x[15:0] & b)) & m;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] x, input logic [3:0] s);
    logic ah, wh, bh;
    @(posedge clk_in);
    awaddr <= ad;
    wdata <= x;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge clk_in);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid & bready;
      r = bresp;
      @(posedge clk_in);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] ad);
    logic ah, rh;
    @(posedge clk_in);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge clk_in);
      ah = arvalid & arready;
      rh = rvalid & rready;
      v = rdata;
      r = rresp;
      @(posedge clk_in);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic check_regs;
    logic [15:0] m;
    rd(`PFSEL_OFS_UPPER);
    chk(v, {16'h0000, up_m});
    chk(32'(r), 32'(`PFSEL_RESP_OKAY));
    rd(`PFSEL_OFS_LOWER);
    chk(v, {16'h0000, lo_m});
    rd(`PFSEL_OFS_DIR);
    chk(v, {16'h0000, dir_m});
    // input pins show the wandering pad, so only output pins are compared
    m = {dir_m[15:8], 8'hFF};
    rd(`PFSEL_OFS_DATA);
    chk(v & 32'(m), 32'(m & dat_m));
  endtask

  task automatic check_pins;
    logic [7:0] sel, oe, dat, busx;
    busx = {1'b0, back_n, cs_n, rd_n, 1'b0};
    for (int i = 0; i < 8; i++) begin
      sel[i] = mode & up_m[2*i];
      oe[i] = sel[i] ? (i > 0 && i < 7) : dir_m[8+i];
      dat[i] = sel[i] ? busx[i] : dat_m[8+i];
    end
    chk(32'(pin_sel), 32'(sel));
    chk(32'(pin_oe), 32'(oe));
    chk(32'(pin_out & oe), 32'(dat & oe));
    chk(32'(req_n_out), 32'(sel[7] ? req_n : 1'b1));
    chk(32'(wait_n_out), 32'(sel[0] ? wait_n : 1'b1));
    chk(32'(clk_oe), 32'(!up_m[15]));
    chk(32'(clk_pin), 32'(clk_src));
    rd(`PFSEL_OFS_STATUS);
    chk(v, {23'h00_0000, mode, sel});
  endtask

  task automatic reset_model;
    up_m = 16'h0015;
    lo_m = 16'h5000;
    dir_m = 16'h0000;
    dat_m = 16'h0000;
  endtask

  task automatic wr_chk(input logic [7:0] ad, input logic [31:0] x, input logic [3:0] s);
    wr(ad, x, s);
    chk(32'(r), 32'(`PFSEL_RESP_OKAY));
    if (ad == `PFSEL_OFS_UPPER) up_m = merge(up_m, x, s, 16'hD555);
    else if (ad == `PFSEL_OFS_LOWER) lo_m = merge(lo_m, x, s, 16'h5D55);
    else if (ad == `PFSEL_OFS_DIR) dir_m = merge(dir_m, x, s, 16'hFFFF);
    else dat_m = merge(dat_m, x, s, 16'hFFFF);
    repeat (2) @(posedge clk_in);
  endtask

  task automatic stim;
    v = xorshift();
    mode <= v[0] | v[10];
    clk_src <= v[1];
    back_n <= v[2];
    cs_n <= v[6:3];
    rd_n <= v[7];
    req_n <= v[8];
    wait_n <= v[9];
  endtask

  initial begin
    rst_in = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {mode, clk_src, back_n, cs_n, rd_n, req_n, wait_n} = 10'h3FF;
    clk_src = 1'b0;
    reset_model();
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    check_regs();
    check_pins();
    $display("test reset values done");
    // reserved bits written once on purpose to see them read back zero
    wr_chk(`PFSEL_OFS_UPPER, 32'h0000_FFFF, 4'h3);
    check_regs();
    check_pins();
    mode <= 1'b0;
    repeat (2) @(posedge clk_in);
    check_pins();
    $display("test reserved bits and single-chip done");
    for (int n = 0; n < 24; n++) begin
      stim();
      d = xorshift();
      a = {4'h0, d[1:0], 2'b00};
      if (a == `PFSEL_OFS_UPPER) d = d & 32'h0000_D555;
      wr_chk(a, d, v[14:11]);
      check_regs();
      check_pins();
    end
    $display("test random selects done");
    wr(8'h14, xorshift(), 4'hF);
    chk(32'(r), 32'(`PFSEL_RESP_SLVERR));
    rd(8'h14);
    chk(v, 32'h0000_0000);
    chk(32'(r), 32'(`PFSEL_RESP_SLVERR));
    wr(`PFSEL_OFS_STATUS, 32'h0000_FFFF, 4'hF);
    chk(32'(r), 32'(`PFSEL_RESP_OKAY));
    check_regs();
    check_pins();
    $display("test unmapped and status done");
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_model();
    check_regs();
    repeat (2) @(posedge clk_in);
    check_pins();
    $display("test reset in mid-run done");
    end_sim();
  end

  // about 21 cycles per random pass, so this span is ample
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    end_sim();
  end
endmodule

`default_nettype wire
